/* common/prio_pkg.sv */
// Constants and carrier types for the priority register block
package prio_pkg;
	// ********************
	// Register map
	// ********************
	localparam logic [3:0]  prio_ctrl_0_off = 4'h0;
	localparam logic [3:0]  prio_ctrl_1_off = 4'h1;
	localparam logic [3:0]  irq_enable_off  = 4'h2;
	localparam logic [3:0]  irq_pending_off = 4'h3;
	localparam logic [3:0]  arb_status_off  = 4'h4;
	// ********************
	// Field layout
	// ********************
	localparam int          field_w       = 3;
	localparam int          n_src         = 8;
	localparam logic [15:0] prio_impl_msk = 16'h7777;
	localparam logic [15:0] prio_reset    = 16'h4444;
	localparam logic [7:0]  enable_reset  = 8'h00;
	localparam logic [2:0]  prio_off_code = 3'h0;
	localparam logic [15:0] bad_addr_data = 16'h0000;
	// Source index: 0..3 in register 0 low to high field, 4..7 in register 1
	localparam int          src_ext_irq_a = 0;
	localparam int          src_dma_a     = 4;

	typedef struct packed {
		logic        valid;
		logic [2:0]  src;
		logic [2:0]  level;
	} arb_s;
endpackage : prio_pkg

/* design/prio_field.sv */
// One 3-bit priority field with its enable and pending qualification
`timescale 1ns/1ps
module prio_field (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_val,
	input  wire logic       enable,
	input  wire logic       pending,
	output logic [2:0]      level_ff,
	output logic [2:0]      bid
);
	// Field storage, loads level 4 at reset
	always_ff @(posedge clock) begin
		if (rst) begin
			level_ff <= prio_pkg::prio_reset[2:0];
		end else if (wr_en) begin
			level_ff <= wr_val;
		end
	end

	// Bid is the level itself; 000 or a blocked request bids nothing
	assign bid = (enable && pending) ? level_ff : prio_pkg::prio_off_code;
endmodule : prio_field

/* design/interrupt_priority_regs.sv */
// Priority control registers and arbitration for eight interrupt sources
`timescale 1ns/1ps
module interrupt_priority_regs (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic [7:0]  irq_pending,
	output logic [15:0]      rdata_ff,
	output logic             req_ff,
	output logic [2:0]       req_src_ff,
	output logic [2:0]       req_level_ff
);
	// ********************
	// Address decode
	// ********************
	wire wr_p0 = wr && (addr == prio_pkg::prio_ctrl_0_off);
	wire wr_p1 = wr && (addr == prio_pkg::prio_ctrl_1_off);
	wire wr_en = wr && (addr == prio_pkg::irq_enable_off);

	logic [7:0]  enable_ff;
	logic [2:0]  level [8];
	logic [2:0]  bid   [8];
	logic [15:0] p0_word;
	logic [15:0] p1_word;
	logic [15:0] nxt_rdata;
	prio_pkg::arb_s win;

	// ********************
	// Priority fields
	// ********************
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_fld
			prio_field u_fld (
				.clock    (clock),
				.rst      (rst),
				.wr_en    ((g < 4) ? wr_p0 : wr_p1),
				.wr_val   (wdata[(g%4)*4 +: 3]),
				.enable   (enable_ff[g]),
				.pending  (irq_pending[g]),
				.level_ff (level[g]),
				.bid      (bid[g])
			);
		end
	endgenerate

	// Gaps between fields read zero
	assign p0_word = {1'b0, level[3], 1'b0, level[2], 1'b0, level[1], 1'b0, level[0]};
	assign p1_word = {1'b0, level[7], 1'b0, level[6], 1'b0, level[5], 1'b0, level[4]};

	// Enable register
	always_ff @(posedge clock) begin
		if (rst) begin
			enable_ff <= prio_pkg::enable_reset;
		end else if (wr_en) begin
			enable_ff <= wdata[7:0];
		end
	end

	// ********************
	// Arbitration
	// ********************
	// Highest bid wins; on a tie the lower source index wins
	always_comb begin
		win = '0;
		for (int i = 0; i < 8; i++) begin
			if (bid[i] > win.level) begin
				win.valid = 1'b1;
				win.src   = 3'(i);
				win.level = bid[i];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			req_ff       <= 1'b0;
			req_src_ff   <= 3'h0;
			req_level_ff <= 3'h0;
		end else begin
			req_ff       <= win.valid;
			req_src_ff   <= win.src;
			req_level_ff <= win.level;
		end
	end

	// ********************
	// Read path
	// ********************
	always_comb begin
		case (addr)
			prio_pkg::prio_ctrl_0_off: nxt_rdata = p0_word;
			prio_pkg::prio_ctrl_1_off: nxt_rdata = p1_word;
			prio_pkg::irq_enable_off:  nxt_rdata = {8'h00, enable_ff};
			prio_pkg::irq_pending_off: nxt_rdata = {8'h00, irq_pending};
			prio_pkg::arb_status_off:  nxt_rdata = {9'h000, req_ff, req_src_ff, req_level_ff};
			default:                   nxt_rdata = prio_pkg::bad_addr_data;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_ff <= 16'h0000;
		end else if (rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 16'h0000;
		end
	end

	// ********************
	// Checks
	// ********************
	a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
		(p0_word & ~prio_pkg::prio_impl_msk) == 0 && (p1_word & ~prio_pkg::prio_impl_msk) == 0)
		else $error("reserved priority bits not zero");
	a_field_write: assert property (@(posedge clock) disable iff (rst)
		wr_p0 |=> level[0] == $past(wdata[2:0]) && level[3] == $past(wdata[14:12]))
		else $error("register 0 field write mismatch");
	a_field_write_b: assert property (@(posedge clock) disable iff (rst)
		wr_p1 |=> level[4] == $past(wdata[2:0]) && level[7] == $past(wdata[14:12]))
		else $error("register 1 field write mismatch");
	a_reset_level: assert property (@(posedge clock)
		rst |=> p0_word == prio_pkg::prio_reset && p1_word == prio_pkg::prio_reset)
		else $error("reset priority not level 4");
	a_disabled_out: assert property (@(posedge clock) disable iff (rst)
		(level[0] == 3'h0) |-> bid[0] == 3'h0)
		else $error("disabled source bids");
	a_enable_block: assert property (@(posedge clock) disable iff (rst)
		!enable_ff[prio_pkg::src_dma_a] |-> bid[prio_pkg::src_dma_a] == 3'h0)
		else $error("blocked source bids");
	a_top_wins: assert property (@(posedge clock) disable iff (rst)
		(bid[0] == 3'h7) |=> req_ff && req_level_ff == 3'h7 && req_src_ff == 3'h0)
		else $error("level 7 bid lost");
	a_winner_max: assert property (@(posedge clock) disable iff (rst)
		win.valid |-> bid[win.src] == win.level && bid[7] <= win.level && bid[1] <= win.level)
		else $error("winner not highest");
	a_read_timing: assert property (@(posedge clock) disable iff (rst)
		(rd && addr == prio_pkg::prio_ctrl_0_off) |=> rdata_ff == $past(p0_word))
		else $error("read data wrong");

	// ********************
	// Named steps of a register read
	// ********************
	// A read is a strobe beside an address, then one cycle of data, then zero.
	// Registers 1 to 4 and the unmapped range each get a step so the read checks below stay short.
	sequence s_rd_p1;
		rd && addr == prio_pkg::prio_ctrl_1_off;
	endsequence

	sequence s_rd_enable;
		rd && addr == prio_pkg::irq_enable_off;
	endsequence

	sequence s_rd_pending;
		rd && addr == prio_pkg::irq_pending_off;
	endsequence

	sequence s_rd_status;
		rd && addr == prio_pkg::arb_status_off;
	endsequence

	sequence s_rd_unmapped;
		rd && addr > prio_pkg::arb_status_off;
	endsequence

	sequence s_rd_none;
		!rd;
	endsequence

	// ********************
	// Read path checks
	// ********************
	// Register 1 reads back its packed fields one cycle after the strobe
	a_read_p1: assert property (@(posedge clock) disable iff (rst)
		s_rd_p1 |=> rdata_ff == $past(p1_word))
		else $error("register 1 read data wrong");

	// Enable register sits in the low byte, high byte reads zero
	a_read_enable: assert property (@(posedge clock) disable iff (rst)
		s_rd_enable |=> rdata_ff == {8'h00, $past(enable_ff)})
		else $error("enable read data wrong");

	// Pending mirror shows the request lines as they stood at the strobe
	a_read_pending: assert property (@(posedge clock) disable iff (rst)
		s_rd_pending |=> rdata_ff == {8'h00, $past(irq_pending)})
		else $error("pending read data wrong");

	// Status word carries the registered winner, not the live one
	a_read_status: assert property (@(posedge clock) disable iff (rst)
		s_rd_status |=> rdata_ff == {9'h000, $past(req_ff), $past(req_src_ff),
			$past(req_level_ff)})
		else $error("status read data wrong");

	// Addresses past the map read as zero
	a_read_unmapped: assert property (@(posedge clock) disable iff (rst)
		s_rd_unmapped |=> rdata_ff == prio_pkg::bad_addr_data)
		else $error("unmapped read not zero");

	// Data stands for one cycle only; without a strobe the bus is zero
	a_read_idle: assert property (@(posedge clock) disable iff (rst)
		s_rd_none |=> rdata_ff == 16'h0000)
		else $error("read data outside its cycle");

	// ********************
	// Write path checks
	// ********************
	// Middle fields of register 0 take their own slices of the write word
	a_mid_write_a: assert property (@(posedge clock) disable iff (rst)
		wr_p0 |=> level[1] == $past(wdata[6:4]) && level[2] == $past(wdata[10:8]))
		else $error("register 0 middle field write mismatch");

	// Middle fields of register 1 likewise
	a_mid_write_b: assert property (@(posedge clock) disable iff (rst)
		wr_p1 |=> level[5] == $past(wdata[6:4]) && level[6] == $past(wdata[10:8]))
		else $error("register 1 middle field write mismatch");

	// Without its strobe register 0 keeps every field
	a_hold_a: assert property (@(posedge clock) disable iff (rst)
		!wr_p0 |=> p0_word == $past(p0_word))
		else $error("register 0 changed without a write");

	// Without its strobe register 1 keeps every field
	a_hold_b: assert property (@(posedge clock) disable iff (rst)
		!wr_p1 |=> p1_word == $past(p1_word))
		else $error("register 1 changed without a write");

	// Enable register takes the low byte of the write
	a_enable_write: assert property (@(posedge clock) disable iff (rst)
		wr_en |=> enable_ff == $past(wdata[7:0]))
		else $error("enable write mismatch");

	// Enable register holds between writes
	a_enable_hold: assert property (@(posedge clock) disable iff (rst)
		!wr_en |=> enable_ff == $past(enable_ff))
		else $error("enable changed without a write");

	// Reset clears the enables, the request and the read bus
	a_reset_enable: assert property (@(posedge clock)
		rst |=> enable_ff == prio_pkg::enable_reset && !req_ff && rdata_ff == 16'h0000)
		else $error("reset state wrong");

	// ********************
	// Arbitration checks
	// ********************
	// A raised request never carries the disabled code
	a_req_level: assert property (@(posedge clock) disable iff (rst)
		req_ff |-> req_level_ff != 3'h0)
		else $error("request at level zero");

	// No bidder means no request and a zero winner
	a_no_req: assert property (@(posedge clock) disable iff (rst)
		!win.valid |=> !req_ff && req_level_ff == 3'h0 && req_src_ff == 3'h0)
		else $error("request without a bidder");

	// The registered outputs follow the live winner by one cycle
	a_req_follows: assert property (@(posedge clock) disable iff (rst)
		win.valid |=> req_ff && req_src_ff == $past(win.src) && req_level_ff == $past(win.level))
		else $error("request does not follow winner");

	// ********************
	// Per-source checks
	// ********************
	// Every source is checked, not only the corner ones, so a slip in one
	// field index of the generate loop cannot hide behind the others.
	genvar c;
	generate
		for (c = 0; c < 8; c++) begin : g_chk
			// Code 000 keeps the source out
			a_zero_bids: assert property (@(posedge clock) disable iff (rst)
				(level[c] == prio_pkg::prio_off_code) |-> bid[c] == 3'h0)
				else $error("disabled source bids");

			// A cleared enable keeps the source out
			a_blocked_bids: assert property (@(posedge clock) disable iff (rst)
				!enable_ff[c] |-> bid[c] == 3'h0)
				else $error("blocked source bids");

			// An enabled pending source bids its own level
			a_live_bids: assert property (@(posedge clock) disable iff (rst)
				(enable_ff[c] && irq_pending[c]) |-> bid[c] == level[c])
				else $error("live source bid wrong");

			// No bid beats the winner
			a_beats_rest: assert property (@(posedge clock) disable iff (rst)
				win.valid |-> bid[c] <= win.level)
				else $error("a higher bid lost");

			// A lower index with an equal bid would have won
			a_tie_low: assert property (@(posedge clock) disable iff (rst)
				(win.valid && c < win.src) |-> bid[c] < win.level)
				else $error("tie not to lowest index");

			// The winner is pending and enabled
			a_win_live: assert property (@(posedge clock) disable iff (rst)
				(win.valid && win.src == c) |-> irq_pending[c] && enable_ff[c])
				else $error("winner not pending and enabled");
		end
	endgenerate
endmodule : interrupt_priority_regs

/* dv/testbench.sv */
// Self-checking bench for the interrupt priority register block
`timescale 1ns/1ps
module testbench;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  irq_pending = 8'h00;
	logic [15:0] rdata_ff;
	logic        req_ff;
	logic [2:0]  req_src_ff;
	logic [2:0]  req_level_ff;
	int          fails = 0;
	int          total_checks = 0;

	interrupt_priority_regs i_interrupt_priority_regs (.clock(clock), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .irq_pending(irq_pending), .rdata_ff(rdata_ff),
		.req_ff(req_ff), .req_src_ff(req_src_ff), .req_level_ff(req_level_ff));

	// 20 MHz clock
	always #25 clock = ~clock;

	// ********************
	// Helpers
	// ********************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata_ff;
	endtask : rd_reg

	// Drive pending lines, then sample the winner one cycle later
	task automatic arb(input logic [7:0] p, output logic [15:0] d);
		@(posedge clock);
		irq_pending <= p;
		@(posedge clock);
		#1 d = {9'h000, req_ff, req_src_ff, req_level_ff};
	endtask : arb

	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// ********************
	// Scenarios
	// ********************
	task automatic reg_access;
		logic [15:0] d;
		rd_reg(prio_pkg::prio_ctrl_0_off, d); chk(d, 16'h4444);
		rd_reg(prio_pkg::prio_ctrl_1_off, d); chk(d, 16'h4444);
		wr_reg(prio_pkg::prio_ctrl_0_off, 16'hffff);
		rd_reg(prio_pkg::prio_ctrl_0_off, d); chk(d, 16'h7777);
		wr_reg(prio_pkg::prio_ctrl_1_off, 16'h8888);
		rd_reg(prio_pkg::prio_ctrl_1_off, d); chk(d, 16'h0000);
		rd_reg(4'hf, d); chk(d, 16'h0000);
	endtask : reg_access

	task automatic arbitration;
		logic [15:0] d;
		wr_reg(prio_pkg::irq_enable_off, 16'h00ff);
		wr_reg(prio_pkg::prio_ctrl_0_off, 16'h0127);
		arb(8'hff, d); chk(d, 16'h0047);
		arb(8'hfe, d); chk(d, 16'h004a);
		arb(8'h04, d); chk(d, 16'h0051);
		arb(8'h08, d); chk(d, 16'h0000);
		wr_reg(prio_pkg::prio_ctrl_1_off, 16'h6035);
		arb(8'hf0, d); chk(d, 16'h007e);
		arb(8'h31, d); chk(d, 16'h0047);
		wr_reg(prio_pkg::irq_enable_off, 16'h007e);
		arb(8'hff, d); chk(d, 16'h0065);
	endtask : arbitration

	// Mirror, enable and status reads, then a reset in mid-run
	task automatic more_reads;
		logic [15:0] d;
		@(posedge clock);
		irq_pending <= 8'h5a;
		rd_reg(prio_pkg::irq_pending_off, d); chk(d, 16'h005a);
		rd_reg(prio_pkg::irq_enable_off, d); chk(d, 16'h007e);
		rd_reg(prio_pkg::arb_status_off, d); chk(d, 16'h0065);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd_reg(prio_pkg::prio_ctrl_1_off, d); chk(d, 16'h4444);
		rd_reg(prio_pkg::irq_enable_off, d); chk(d, 16'h0000);
		arb(8'hff, d); chk(d, 16'h0000);
	endtask : more_reads

	// ********************
	// Main sequence and watchdog
	// ********************
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		reg_access();
		arbitration();
		more_reads();
		wrap_up();
	end

	initial begin
		#200000;
		fails++;
		wrap_up();
	end
endmodule : testbench
